// file: bench/esp_port_ctrl_props.sv
// pin timing assertions for the sram port controller
// assumes it is bound into esp_port_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module esp_port_ctrl_props (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic [3:0]  regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regWrStb,
    input wire logic        regRdStb,
    input wire logic [15:0] regRdData,
    input wire logic        rdValid,
    input wire logic [15:0] addressLines,
    input wire logic        dataLinesOe,
    input wire logic        memorySelectN,
    input wire logic        readStrobeN,
    input wire logic        writeStrobeN,
    input wire logic        addressTraceN,
    input wire logic        clockOutput
);
    logic [4:0] waitReg;
    logic [6:0] wrLow;
    logic [6:0] selHigh;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    function automatic logic [6:0] wrLen(input logic [4:0] w);
        return 7'(w <= 5'h01 ? 2 * w + 3 :
                  (w <= 5'h03 ? 2 * w + 2 : 2 * w + 1));
    endfunction
    function automatic logic [6:0] trail(input logic [4:0] w);
        return w >= 5'h08 ? 7'h04 : (w >= 5'h04 ? 7'h02 : 7'h00);
    endfunction
    // wait shadow; idle count starts saturated so reset is no gap
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            waitReg <= 5'h1F;
            wrLow   <= 7'h00;
            selHigh <= 7'h7F;
        end else begin
            if (regWrStb && regAddr == 4'h0)
                waitReg <= regWrData[4:0];
            wrLow <= writeStrobeN ? 7'h00 : wrLow + 7'h01;
            if (!memorySelectN)
                selHigh <= 7'h00;
            else if (selHigh != 7'h7F)
                selHigh <= selHigh + 7'h01;
        end
    end
    a_reset_pins: assert property (
        $past(reset) |-> addressLines == 16'hFFFF && memorySelectN &&
        readStrobeN && writeStrobeN && addressTraceN && !dataLinesOe)
        else $error("pins not parked after reset");
    a_addr_idle: assert property (
        !$past(reset) && !$stable(addressLines)
        |-> !memorySelectN || !addressTraceN)
        else $error("address moved with no access");
    a_addr_stable: assert property (
        (!readStrobeN && !$past(readStrobeN)) ||
        (!writeStrobeN && !$past(writeStrobeN)) |-> $stable(addressLines))
        else $error("address moved under a strobe");
    a_strobe_sel: assert property (
        !readStrobeN || !writeStrobeN
        |-> !memorySelectN && (readStrobeN || writeStrobeN))
        else $error("strobe without select");
    a_sel_low_phase: assert property (
        $fell(memorySelectN) |-> !clockOutput)
        else $error("select not in clock low phase");
    a_rd_rise: assert property (
        $fell(readStrobeN) |-> clockOutput && !$past(memorySelectN))
        else $error("read strobe not at rising clock");
    a_wr_len: assert property (
        $rose(writeStrobeN) |-> wrLow == wrLen(waitReg))
        else $error("write strobe length wrong");
    a_trail_gap: assert property (
        $fell(memorySelectN) |-> selHigh >= trail(waitReg))
        else $error("trailing states missing");
    a_trace_pulse: assert property (
        !addressTraceN |=> addressTraceN)
        else $error("trace pulse too long");
    a_oe_start: assert property (
        $rose(dataLinesOe) |-> !memorySelectN && readStrobeN)
        else $error("data driven outside a write");
    a_rd_valid: assert property (
        rdValid |-> !$past(readStrobeN))
        else $error("read result without read strobe");
    a_reg_rsvd: assert property (
        regRdStb |=> regRdData[15:5] == 11'h000)
        else $error("reserved bits not zero");
    c_write: cover property ($rose(writeStrobeN));
    c_read: cover property (rdValid);
    c_trace: cover property (!addressTraceN && memorySelectN);
endmodule
bind esp_port_ctrl esp_port_ctrl_props u_props (
    .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .rdValid(rdValid), .addressLines(addressLines),
    .dataLinesOe(dataLinesOe), .memorySelectN(memorySelectN),
    .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
    .addressTraceN(addressTraceN), .clockOutput(clockOutput)
);
`default_nettype wire

// file: bench/esp_sram_model.sv
// behavioural static ram on the far side of the memory pins
// assumes select and strobes active low; 256 words decoded
`timescale 1ns/1ps
`default_nettype none
module esp_sram_model (
    input  wire logic        clk_sys,
    input  wire logic [15:0] addressLines,
    input  wire logic [23:0] dataLinesOut,
    input  wire logic        dataLinesOe,
    input  wire logic        memorySelectN,
    input  wire logic        readStrobeN,
    input  wire logic        writeStrobeN,
    output wire logic [23:0] dataLinesIn
);
    logic [23:0] mem [256];
    logic [23:0] noise = 24'h5A3C96;
    // store relies on the strobe window
    always @(posedge clk_sys) begin
        noise <= ~noise;
        if (!memorySelectN && !writeStrobeN && dataLinesOe)
            mem[addressLines[7:0]] <= dataLinesOut;
    end
    // released bus toggles so a stale value never passes for data
    assign dataLinesIn = dataLinesOe ? dataLinesOut :
        (!memorySelectN && !readStrobeN) ? mem[addressLines[7:0]] : noise;
endmodule
`default_nettype wire

// file: bench/external_sram_port_controller_tb_top.sv
// self-checking bench for the external sram port controller
// assumes the ram model on the pins and the bound checker
`include "esp_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module external_sram_port_controller_tb_top;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic        regWrStb = 1'b0, regRdStb = 1'b0, traceValid = 1'b0;
    logic        reqValid = 1'b0, reqWrite = 1'b0;
    logic [15:0] reqAddr = 16'h0000, traceAddr = 16'h0000;
    logic [23:0] reqData = 24'h000000;
    logic [15:0] regRdData, addressLines, holdAddr;
    logic [23:0] rdData, dataLinesIn, dataLinesOut, expData;
    logic        reqReady, rdValid, dataLinesOe, memorySelectN;
    logic        readStrobeN, writeStrobeN, addressTraceN, clockOutput;
    logic [31:0] rnd = 32'hA7CF28E3;
    int          failures = 0, nChecks = 0, n, k0, i;
    logic [4:0]  waits [8] = '{5'h01, 5'h00, 5'h02, 5'h03, 5'h04, 5'h07,
                              5'h08, 5'h1F};
    esp_port_ctrl uut (
        .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
        .rdValid(rdValid), .rdData(rdData), .traceValid(traceValid),
        .traceAddr(traceAddr), .addressLines(addressLines),
        .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
        .dataLinesOe(dataLinesOe), .memorySelectN(memorySelectN),
        .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
        .addressTraceN(addressTraceN), .clockOutput(clockOutput)
    );
    esp_sram_model ram (
        .clk_sys(clk_sys), .addressLines(addressLines),
        .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe),
        .memorySelectN(memorySelectN), .readStrobeN(readStrobeN),
        .writeStrobeN(writeStrobeN), .dataLinesIn(dataLinesIn)
    );
    // free-running 10 MHz clock
    always #50 clk_sys = ~clk_sys;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp,
                         input string what);
        nChecks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic regWr(input logic [3:0] a, input logic [15:0] d);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge clk_sys);
        regWrStb  <= 1'b0;
    endtask
    task automatic regRd(input logic [3:0] a, input logic [15:0] e,
                         input string w);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge clk_sys);
        regRdStb <= 1'b0;
        @(posedge clk_sys);
        check({8'h00, regRdData}, {8'h00, e}, w);
    endtask
    // keep leaves the request up so a second one follows with no gap
    task automatic access(input logic wr, input logic [15:0] a,
                          input logic [23:0] d, input logic keep,
                          output int lat);
        int k;
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqAddr  <= a;
        reqData  <= d;
        k = 0;
        lat = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (reqReady !== 1'b1 && k < 300);
        if (!keep)
            reqValid <= 1'b0;
        while (!wr && rdValid !== 1'b1 && lat < 300) begin
            @(posedge clk_sys);
            lat++;
        end
        // a limit that runs out counts as a mismatch
        if (k >= 300 || lat >= 300)
            failures++;
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watchdog: whole sequence needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        check({8'h00, addressLines}, 24'h00FFFF, "addr");
        check({19'h0, memorySelectN, readStrobeN, writeStrobeN,
               addressTraceN, dataLinesOe}, 24'h00001E, "pins");
        reset <= 1'b0;
        @(posedge clk_sys);
        regRd(`ESP_OFS_BUSCTL, 16'h001F, "busctl");
        regWr(`ESP_OFS_BUSCTL, 16'hFFE3);
        regRd(`ESP_OFS_BUSCTL, 16'h0003, "rsvd");
        regWr(4'hF, 16'hFFFF);
        regRd(4'hF, 16'h0000, "unmapped");
        regRd(`ESP_OFS_OPMODE, 16'h0000, "opmode");
        // every wait class, write then read back to back
        for (i = 0; i < 8; i++) begin
            regWr(`ESP_OFS_BUSCTL, {11'h000, waits[i]});
            repeat (4) @(posedge clk_sys);
            rnd = lfsr(rnd);
            expData = rnd[23:0];
            access(1'b1, {rnd[31:24], i[7:0]}, expData, 1'b1, n);
            access(1'b0, {rnd[31:24], i[7:0]}, 24'h000000, 1'b0, n);
            check(rdData, expData, "rdata");
            // rdValid stands in half 2*(w+2), seen one edge later
            check(24'(n), 24'(5 + 2 * waits[i]), "latency");
        end
        regWr(`ESP_OFS_OPMODE, 16'h0001);
        traceAddr  <= rnd[15:0];
        traceValid <= 1'b1;
        for (n = 0; n < 50 && addressTraceN !== 1'b0; n++)
            @(posedge clk_sys);
        if (n >= 50)
            failures++;
        check({8'h00, addressLines}, {8'h00, traceAddr}, "trace");
        check({21'h0, memorySelectN, readStrobeN, writeStrobeN},
              24'h000007, "tsel");
        traceValid <= 1'b0;
        // a stray trace launch would now move the address
        traceAddr  <= ~traceAddr;
        @(posedge clk_sys);
        holdAddr = addressLines;
        repeat (10) @(posedge clk_sys);
        check({8'h00, addressLines}, {8'h00, holdAddr}, "hold");
        access(1'b1, 16'h0042, rnd[23:0], 1'b0, n);
        @(posedge clk_sys);
        check({23'h0, addressTraceN}, 24'h000000, "trext");
        regWr(`ESP_OFS_OPMODE, 16'h0002);
        // drain the long write so only the disable can hold ready low
        repeat (80) @(posedge clk_sys);
        reqValid <= 1'b1;
        k0 = 0;
        repeat (20) begin
            @(posedge clk_sys);
            k0 += (reqReady !== 1'b0);
        end
        reqValid <= 1'b0;
        check(24'(k0), 24'h000000, "disable");
        regRd(`ESP_OFS_STATUS, 16'h0000, "status");
        summarize();
    end
endmodule
`default_nettype wire

// file: verilog/esp_clock_phase.v
// clock output divider: one clock output phase per clk_sys cycle
// assumes clk_sys is the core clock; output toggles every cycle
`timescale 1ns/1ps
`default_nettype none
module esp_clock_phase (
    input  wire clk_sys,
    input  wire reset,
    output reg  clkOutReg
);
    // held high in reset, first low phase follows the release
    always @(posedge clk_sys) begin
        if (reset) begin
            clkOutReg <= 1'b1;
        end else begin
            clkOutReg <= ~clkOutReg;
        end
    end
endmodule
`default_nettype wire

// file: verilog/esp_consts.vh
// constants of the external sram port controller
// assumes it is included by bare name from the design files
`ifndef ESP_CONSTS_VH
`define ESP_CONSTS_VH

// register word offsets on the plain register port
`define ESP_OFS_BUSCTL      4'h0
`define ESP_OFS_OPMODE      4'h1
`define ESP_OFS_STATUS      4'h2

// bus control field layout and reset value
`define ESP_WAIT_MSB        4
`define ESP_WAIT_LSB        0
`define ESP_BUSCTL_RESET    16'h001F
`define ESP_WAIT_RESET      5'h1F

// operating mode bit positions
`define ESP_TRACE_EN_BIT    0
`define ESP_BUS_DIS_BIT     1

// wait thresholds for trailing states and write strobe delay
`define ESP_WAIT_ONE        5'h01
`define ESP_WAIT_THREE      5'h03
`define ESP_WAIT_TRAIL1     5'h04
`define ESP_WAIT_TRAIL2     5'h08

// access timing in half cycles of the clock output
`define ESP_BASE_HALVES     7'h04
`define ESP_TRACE_HALVES    7'h02

// pin levels during reset
`define ESP_ADDR_RESET      16'hFFFF

// fsm codes
`define ESP_ST_IDLE         2'h0
`define ESP_ST_EXT          2'h1
`define ESP_ST_TRACE        2'h2

`endif

// file: verilog/esp_port_ctrl.v
// external sram port controller: core request side, register port,
// and the memory pins (address, data, select, strobes, trace, clock)
// assumes the core and register master run on clk_sys at 10 MHz
// assumes the core holds a request until it sees ready
// assumes reset stands at least one edge; the pad synchroniser clears both stages on it
// limitation: a wait count written mid-access counts from the next one
//
// Functional notes
// RULE1 - 24-bit data path, 16-bit address out
// RULE2 - one access per two clocks, zero waits
// RULE3 - address holds when bus is idle
// RULE4 - address lines high during reset
// RULE5 - data lines released when idle, reset
// RULE6 - select low per access, high in reset
// RULE7 - read strobe low on reads only
// RULE8 - write strobe low on writes only
// RULE9 - trace pulse half cycle per new address
// RULE10 - trace fetches, program moves, external accesses
// RULE11 - wait count taken from bus control
// RULE12 - address stable through whole access
// RULE13 - software programs at least one wait
// RULE14 - write: address, select, data in low
// RULE15 - read: strobe at rise, sample last high
// RULE16 - write strobe delay depends on waits
// RULE17 - bus disable shuts the port down
// RULE18 - 16-bit control register, reserved read zero
// RULE19 - low five bits give 0 to 31 waits
// RULE20 - trailing states for 4-7 and 8+ waits
// RULE21 - reset loads wait count 31
// RULE22 - trace addresses only when bus free
// RULE23 - trace cycles keep strobes, select high
// RULE24 - zero waits runs base length anyway
//
// The plain strobed port and the register offsets are this design's own decisions.
`include "esp_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module esp_port_ctrl (
    input  wire        clk_sys,
    input  wire        reset,
    // register port
    input  wire [3:0]  regAddr,
    input  wire [15:0] regWrData,
    input  wire        regWrStb,
    input  wire        regRdStb,
    output reg  [15:0] regRdData,
    // core access requests
    input  wire        reqValid,
    input  wire        reqWrite,
    input  wire [15:0] reqAddr,
    input  wire [23:0] reqData,
    output reg         reqReady,
    output reg         rdValid,
    output reg  [23:0] rdData,
    // internal fetch / program move addresses for tracing
    input  wire        traceValid,
    input  wire [15:0] traceAddr,
    // memory pins
    output reg  [15:0] addressLines,
    input  wire [23:0] dataLinesIn,
    output reg  [23:0] dataLinesOut,
    output reg         dataLinesOe,
    output reg         memorySelectN,
    output reg         readStrobeN,
    output reg         writeStrobeN,
    output reg         addressTraceN,
    output wire        clockOutput
);
    // programmed settings
    reg  [4:0]  waitCount_reg;
    reg         traceEnable_reg;
    reg         busDisable_reg;

    // sequencer state and per-access snapshot
    reg  [1:0]  state_reg;
    reg  [6:0]  half_reg;
    reg  [4:0]  accWait_reg;
    reg         accWrite_reg;

    // clock phase and synchronised pads
    wire        clkOutNow;
    wire [23:0] dataSync;

    // access length and strobe timing, in halves; trailing states in cycles
    wire [6:0]  accessHalves;
    wire [1:0]  trailCycles;
    wire [6:0]  totalHalves;
    wire [6:0]  wrStartHalf;
    wire [6:0]  nextHalf;

    // slot bookkeeping
    wire        extEnd;
    wire        traceEnd;
    wire        slotFree;
    wire        launchExt;
    wire        launchTrace;
    wire        readyNext;

    // clock output: low and high phase each one clk_sys cycle
    // a pin, so it comes straight from the divider flip-flop
    esp_clock_phase uClk (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .clkOutReg (clkOutNow)
    );
    assign clockOutput = clkOutNow;

    // the data pads are the only inputs not born on clk_sys
    // read data pins cross into clk_sys before use
    esp_sync2 #(
        .WIDTH (24)
    ) uSync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pinIn   (dataLinesIn),
        .syncOut (dataSync)
    );

    // RULE11 timing from wait count
    // snapshot at launch so a mid-access write cannot skew timing
    // seven bits: 31 waits plus trailing states reach 70 halves
    assign accessHalves = {1'b0, accWait_reg, 1'b0} + `ESP_BASE_HALVES;
    // RULE20 trailing hold states
    assign trailCycles  = (accWait_reg >= `ESP_WAIT_TRAIL2) ? 2'h2 :
                          (accWait_reg >= `ESP_WAIT_TRAIL1) ? 2'h1 : 2'h0;
    assign totalHalves  = accessHalves + {4'h0, trailCycles, 1'b0};
    // RULE16 write strobe delay
    assign wrStartHalf  = (accWait_reg <= `ESP_WAIT_ONE)   ? 7'h01 :
                          (accWait_reg <= `ESP_WAIT_THREE) ? 7'h02 : 7'h03;
    assign nextHalf     = half_reg + 7'h01;

    // a slot is free when idle or in its very last half
    // slot ends on a high phase, so a new one can start right after
    assign extEnd   = (state_reg == `ESP_ST_EXT) &&
                      (half_reg == totalHalves - 7'h01);
    assign traceEnd = (state_reg == `ESP_ST_TRACE) &&
                      (half_reg == `ESP_TRACE_HALVES - 7'h01);
    assign slotFree = (state_reg == `ESP_ST_IDLE) || extEnd || traceEnd;

    // RULE2 back to back launch
    // launches happen only on a high phase so outputs move in low phase
    assign launchExt   = slotFree && clkOutNow && reqValid && reqReady;
    // RULE22 trace only when bus free
    assign launchTrace = slotFree && clkOutNow && !launchExt &&
                         traceEnable_reg && traceValid && !busDisable_reg;

    // RULE17 disabled port takes no requests
    // ready is raised for the coming high phase when a slot frees there
    // a request missing this one-cycle window waits a clock output period
    assign readyNext = !busDisable_reg && !clkOutNow &&
                       ((state_reg == `ESP_ST_IDLE) ||
                        ((state_reg == `ESP_ST_EXT) &&
                         (half_reg == totalHalves - 7'h02)) ||
                        ((state_reg == `ESP_ST_TRACE) &&
                         (half_reg == `ESP_TRACE_HALVES - 7'h02)));

    // register map, word indexed:
    //   0  bus control, wait count in bits 4:0
    //   1  operating mode, trace enable bit 0, bus disable bit 1
    //   2  status, state in bits 2:1, ready in bit 0

    // register writes
    always @(posedge clk_sys) begin
        if (reset) begin
            // RULE21 wait count resets to 31
            waitCount_reg   <= `ESP_WAIT_RESET;
            traceEnable_reg <= 1'b0;
            busDisable_reg  <= 1'b0;
        end else if (regWrStb) begin
            // RULE13 zero not blocked
            // RULE24 no correction of zero
            if (regAddr == `ESP_OFS_BUSCTL) begin
                // reserved bits 15:5 are dropped and read back zero
                // RULE19 low five bits only
                waitCount_reg <= regWrData[`ESP_WAIT_MSB:`ESP_WAIT_LSB];
            end
            if (regAddr == `ESP_OFS_OPMODE) begin
                // disable only blocks launches, a running access ends
                traceEnable_reg <= regWrData[`ESP_TRACE_EN_BIT];
                busDisable_reg  <= regWrData[`ESP_BUS_DIS_BIT];
            end
        end
    end

    // register reads: data stands one cycle after the strobe only
    // status lets software see the sequencer and the ready flag
    always @(posedge clk_sys) begin
        if (reset) begin
            regRdData <= 16'h0000;
        end else if (regRdStb) begin
            case (regAddr)
                // RULE18 reserved bits read zero
                `ESP_OFS_BUSCTL: regRdData <= {11'h000, waitCount_reg};
                `ESP_OFS_OPMODE: regRdData <= {14'h0000, busDisable_reg,
                                               traceEnable_reg};
                `ESP_OFS_STATUS: regRdData <= {13'h0000, state_reg,
                                               reqReady};
                default:         regRdData <= 16'h0000;
            endcase
        end else begin
            regRdData <= 16'h0000;
        end
    end

    // request handshake flag
    // registered so the core never sees a combinational glitch
    always @(posedge clk_sys) begin
        if (reset) begin
            reqReady <= 1'b0;
        end else begin
            reqReady <= readyNext;
        end
    end

    // RULE15 read sample last high
    // own process, so a back-to-back launch cannot swallow the capture;
    // the synced pads trail the pins by two cycles
    always @(posedge clk_sys) begin
        if (reset) begin
            rdValid <= 1'b0;
            rdData  <= 24'h000000;
        end else begin
            rdValid <= 1'b0;
            if ((state_reg == `ESP_ST_EXT) && !accWrite_reg &&
                (half_reg == accessHalves - 7'h01)) begin
                rdData  <= dataSync;
                rdValid <= 1'b1;
            end
        end
    end

    // access timeline, one clk_sys cycle per half of the clock output:
    //   h0          address, select and write data move, low phase
    //   h1          read strobe falls with the rising edge
    //   h1 to h3    write strobe falls, later for longer wait counts
    //   A-1         last access half, the pads are sampled
    //   A to A+2T-1 trailing halves, select high, write data held
    //   the last half may launch the next request back to back
    // with A = 2 * (waits + 2) and T trailing cycles of 0, 1 or 2
    // access sequencer and pin drivers
    always @(posedge clk_sys) begin
        if (reset) begin
            // parked: no access running, pins at their reset levels
            state_reg     <= `ESP_ST_IDLE;
            half_reg      <= 7'h00;
            accWait_reg   <= `ESP_WAIT_RESET;
            accWrite_reg  <= 1'b0;
            // RULE4 address high in reset
            addressLines  <= `ESP_ADDR_RESET;
            dataLinesOut  <= 24'h000000;
            // RULE5 data released in reset
            dataLinesOe   <= 1'b0;
            // RULE6 select high in reset
            memorySelectN <= 1'b1;
            // RULE7 read strobe high in reset
            readStrobeN   <= 1'b1;
            // RULE8 write strobe high in reset
            writeStrobeN  <= 1'b1;
            // RULE9 trace idle in reset
            addressTraceN <= 1'b1;
        end else begin
            if (launchExt) begin
                // select drops with the address, write data alongside
                // RULE14 address, select, data
                // RULE1 full width transfer
                state_reg     <= `ESP_ST_EXT;
                half_reg      <= 7'h00;
                accWait_reg   <= waitCount_reg;
                accWrite_reg  <= reqWrite;
                addressLines  <= reqAddr;
                dataLinesOut  <= reqData;
                dataLinesOe   <= reqWrite;
                memorySelectN <= 1'b0;
                readStrobeN   <= 1'b1;
                writeStrobeN  <= 1'b1;
                // RULE10 external address traced
                addressTraceN <= ~traceEnable_reg;
            end else if (launchTrace) begin
                // address only, so no device wakes up
                // RULE23 no strobes on trace
                // RULE10 fetch or move traced
                state_reg     <= `ESP_ST_TRACE;
                half_reg      <= 7'h00;
                addressLines  <= traceAddr;
                dataLinesOe   <= 1'b0;
                memorySelectN <= 1'b1;
                readStrobeN   <= 1'b1;
                writeStrobeN  <= 1'b1;
                addressTraceN <= 1'b0;
            end else begin
                // RULE9 trace pulse one half
                addressTraceN <= 1'b1;
                case (state_reg)
                    `ESP_ST_EXT: begin
                        // RULE12 address held all access
                        half_reg <= nextHalf;
                        // RULE6 select over access time
                        memorySelectN <= ~(nextHalf < accessHalves);
                        // RULE7 read strobe from rise
                        // RULE15 strobe on rising edge
                        readStrobeN   <= ~(!accWrite_reg &&
                                           nextHalf >= 7'h01 &&
                                           nextHalf < accessHalves);
                        // RULE8 write strobe window
                        // RULE16 delayed start by waits
                        writeStrobeN  <= ~(accWrite_reg &&
                                           nextHalf >= wrStartHalf &&
                                           nextHalf < accessHalves);
                        // RULE20 data held in trailing states
                        dataLinesOe   <= accWrite_reg &&
                                         (nextHalf < totalHalves);
                        if (extEnd) begin
                            // RULE3 address keeps last value
                            state_reg   <= `ESP_ST_IDLE;
                            dataLinesOe <= 1'b0;
                        end
                    end

                    `ESP_ST_TRACE: begin
                        // two halves, trace pin back high after the first, other pins untouched
                        half_reg <= nextHalf;
                        if (traceEnd) begin
                            state_reg <= `ESP_ST_IDLE;
                        end
                    end

                    `ESP_ST_IDLE: begin
                        // RULE5 data released when idle
                        // RULE3 address not toggled
                        dataLinesOe   <= 1'b0;
                        memorySelectN <= 1'b1;
                        readStrobeN   <= 1'b1;
                        writeStrobeN  <= 1'b1;
                    end

                    default: begin
                        // unused code, park in idle
                        state_reg   <= `ESP_ST_IDLE;
                        dataLinesOe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: verilog/esp_sync2.v
// two-stage synchroniser for a group of pin inputs
// assumes the pins are asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module esp_sync2 #(
    parameter WIDTH = 24
) (
    input  wire             clk_sys,
    input  wire             reset,
    input  wire [WIDTH-1:0] pinIn,
    output reg  [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1Reg;

    // first stage feeds the second only
    always @(posedge clk_sys) begin
        if (reset) begin
            stage1Reg <= {WIDTH{1'b0}};
            syncOut   <= {WIDTH{1'b0}};
        end else begin
            stage1Reg <= pinIn;
            syncOut   <= stage1Reg;
        end
    end
endmodule
`default_nettype wire
